// File: access_port.sv
// One register access port: decodes three word offsets, answers a cycle later.
// Assumes a single-cycle request strobe synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module access_port #(
    parameter logic [15:0] DOORBELL_OFF = 16'h0000,
    parameter logic [15:0] CAUSE_OFF    = 16'h0004,
    parameter logic [15:0] BLOCK_OFF    = 16'h0008
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [15:0] addr,
    input  wire logic [31:0] doorbell_word,
    input  wire logic [31:0] cause_word,
    input  wire logic [31:0] block_word,
    output logic             wr_doorbell,
    output logic             wr_cause,
    output logic             wr_block,
    output logic             ack,
    output logic [31:0]      rdata
);
    logic        next_ack;
    logic [31:0] next_rdata;

    // Offsets must be word aligned
    if (DOORBELL_OFF[1:0] != 2'h0 || CAUSE_OFF[1:0] != 2'h0 ||
        BLOCK_OFF[1:0] != 2'h0) begin : g_bad_off
        $error("access_port: unaligned offset");
    end

    // Write decode
    assign wr_doorbell = req && we && addr == DOORBELL_OFF;
    assign wr_cause    = req && we && addr == CAUSE_OFF;
    assign wr_block    = req && we && addr == BLOCK_OFF;

    // Read mux; unmapped offsets read zero
    always_comb begin
        next_ack   = req;
        next_rdata = 32'h0000_0000;
        if (req && !we) begin
            if (addr == DOORBELL_OFF)   next_rdata = doorbell_word;
            else if (addr == CAUSE_OFF) next_rdata = cause_word;
            else if (addr == BLOCK_OFF) next_rdata = block_word;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ack   <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            ack   <= next_ack;
            rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// File: irq_router.sv
// Gates the cause bits by the block bits and drives the four open-drain lines.
// Assumes cause and block are stable register values from the parent.
`timescale 1ns/1ps
`default_nettype none
module irq_router (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [7:0] cause,
    input  wire logic [7:0] block,
    input  wire logic [2:0] pin_sel,
    output logic [3:0]      line_oe
);
    logic [7:0] allowed;
    logic       shared_req;
    logic [3:0] next_line_oe;

    // A source counts only when set and not blocked
    assign allowed    = cause & ~block; // [RULE13] [RULE19]
    assign shared_req = allowed[outbound_doorbell_pkg::ST_POSTQ_BIT]  // [RULE15]
                      | allowed[outbound_doorbell_pkg::ST_SOFT_BIT]   // [RULE16]
                      | allowed[outbound_doorbell_pkg::ST_MSG1_BIT]   // [RULE17]
                      | allowed[outbound_doorbell_pkg::ST_MSG0_BIT];

    // Dedicated lines plus the shared request on the configured pin
    always_comb begin
        next_line_oe = allowed[outbound_doorbell_pkg::ST_LINE_D_BIT:
                               outbound_doorbell_pkg::ST_LINE_A_BIT]; // [RULE14]
        if (pin_sel >= outbound_doorbell_pkg::PIN_A && pin_sel <= outbound_doorbell_pkg::PIN_D)
            next_line_oe[pin_sel[1:0] - 2'd1] = next_line_oe[pin_sel[1:0] - 2'd1]
                                               | shared_req; // [RULE4]
    end

    always_ff @(posedge clk) begin
        if (srst) line_oe <= 4'h0;
        else      line_oe <= next_line_oe; // [RULE19]
    end
endmodule
`default_nettype wire

// File: odb_props.sv
// Port checker for the outbound doorbell interrupt unit.
// Assumes the unit's top ports only; bound below.
`timescale 1ns/1ps
`default_nettype none
module odb_props #(
    parameter int PTR_W = 16
) (
    input wire logic             clk,
    input wire logic             srst,
    input wire logic             lb_req,
    input wire logic             lb_we,
    input wire logic [15:0]      lb_addr,
    input wire logic             lb_ack,
    input wire logic [31:0]      lb_rdata,
    input wire logic             cfg_req,
    input wire logic             cfg_we,
    input wire logic [15:0]      cfg_addr,
    input wire logic             cfg_ack,
    input wire logic [31:0]      cfg_rdata,
    input wire logic [PTR_W-1:0] postq_head,
    input wire logic [PTR_W-1:0] postq_tail,
    input wire logic [3:0]       host_irq_line_n_out,
    input wire logic [3:0]       host_irq_line_n_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Read decodes
    wire logic lb_rd_c = lb_req && !lb_we && lb_addr == 16'h1330;
    wire logic cf_rd_c = cfg_req && !cfg_we && cfg_addr == 16'h0030;
    wire logic cf_rd_b = cfg_req && !cfg_we && cfg_addr == 16'h0034;
    // Queue pending, as the cause bit should show it one cycle later
    wire logic postq_busy = postq_head != postq_tail;
    property p_lb_ack; lb_req |=> lb_ack; endproperty
    a_lb_ack: assert property (p_lb_ack) else $error("local ack missing");
    property p_cfg_idle; !cfg_req |=> !cfg_ack; endproperty
    a_cfg_idle: assert property (p_cfg_idle) else $error("stray cfg ack");
    property p_out_low; host_irq_line_n_out == 4'h0; endproperty
    a_out_low: assert property (p_out_low) else $error("line driven high");
    property p_rsv_lb; lb_rd_c |=> lb_rdata[31:8] == 24'h0; endproperty
    a_rsv_lb: assert property (p_rsv_lb) else $error("cause upper bits set");
    property p_rsv_cfg; cf_rd_c |=> cfg_rdata[31:8] == 24'h0; endproperty
    a_rsv_cfg: assert property (p_rsv_cfg) else $error("cfg cause upper set");
    property p_postq; lb_rd_c |=> lb_rdata[3] == $past(postq_busy); endproperty
    a_postq: assert property (p_postq) else $error("queue flag wrong");
    property p_block_rsv; cf_rd_b |=> cfg_rdata[31:7] == 25'h0; endproperty
    a_block_rsv: assert property (p_block_rsv) else $error("mask upper set");
    property p_quiet; $fell(srst) |-> host_irq_line_n_oe == 4'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("line busy at reset");
    // Main scenarios seen
    c_rd: cover property (lb_rd_c);
    c_irq: cover property (host_irq_line_n_oe != 4'h0);
    c_blk: cover property (cf_rd_b);
endmodule
bind outbound_doorbell_interrupt_unit odb_props #(.PTR_W(PTR_W)) i_odb_props (
    .clk(clk), .srst(srst), .lb_req(lb_req), .lb_we(lb_we), .lb_addr(lb_addr),
    .lb_ack(lb_ack), .lb_rdata(lb_rdata), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .postq_head(postq_head), .postq_tail(postq_tail),
    .host_irq_line_n_out(host_irq_line_n_out), .host_irq_line_n_oe(host_irq_line_n_oe));
`default_nettype wire

// File: outbound_doorbell_interrupt_unit.sv
// Outbound doorbell, cause and block registers of the message exchange unit.
// Assumes the local bus and the PCI configuration path each present one
// request strobe per access, and message writes arrive as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RULE1] Doorbell bit 29 drives interrupt line B
// [RULE2] Doorbell bit 28 drives interrupt line A
// [RULE3] Any soft bit 27:0 raises interrupt
// [RULE4] Soft interrupt uses configured pin
// [RULE5] PCI doorbell access is clear-type
// [RULE6] Cause 7:4 mirror doorbell line bits
// [RULE7] Cause 3 set while head differs tail
// [RULE8] Cause 2 set while any soft bit
// [RULE9] Message writes set cause 1 and 0
// [RULE10] Local side clears message cause bits
// [RULE11] Cause bits 31:8 reserved, zero
// [RULE12] PCI cause access never stores data; here PCI cause writes of ones clear message bits 1:0
// [RULE13] Block bit one suppresses, resets zero
// [RULE14] Block 6:4 suppress lines C, B, A
// [RULE15] Block 3 suppresses post queue interrupt
// [RULE16] Block 2 suppresses soft doorbell interrupt
// [RULE17] Block 1:0 suppress message interrupts
// [RULE18] PCI block register is readable, writable
// [RULE19] Registered cause and not block gating
module outbound_doorbell_interrupt_unit #(
    parameter int PTR_W = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    // Local bus access port
    input  wire logic             lb_req,
    input  wire logic             lb_we,
    input  wire logic [15:0]      lb_addr,
    input  wire logic [31:0]      lb_wdata,
    output logic                  lb_ack,
    output logic [31:0]           lb_rdata,
    // PCI configuration access port
    input  wire logic             cfg_req,
    input  wire logic             cfg_we,
    input  wire logic [15:0]      cfg_addr,
    input  wire logic [31:0]      cfg_wdata,
    output logic                  cfg_ack,
    output logic [31:0]           cfg_rdata,
    // Outbound message register write pulses
    input  wire logic             msg0_written,
    input  wire logic             msg1_written,
    // Outbound post queue pointers
    input  wire logic [PTR_W-1:0] postq_head,
    input  wire logic [PTR_W-1:0] postq_tail,
    // Interrupt pin setting of the address translation unit
    input  wire logic [2:0]       irq_pin_sel,
    // Open-drain interrupt lines, index 0 is line A
    output logic [3:0]            host_irq_line_n_out,
    output logic [3:0]            host_irq_line_n_oe
);
    // Pointer width must be usable
    if (PTR_W < 1 || PTR_W > 32) begin : g_bad_ptr_w
        $error("outbound_doorbell_interrupt_unit: PTR_W out of range");
    end

    // Register state
    logic [31:0] host_doorbell_out;
    logic [7:0]  host_irq_block;
    logic [1:0]  msg_flag;
    logic [31:0] next_doorbell;
    logic [7:0]  next_block;
    logic [1:0]  next_msg_flag;

    // Live cause view
    logic [7:0]  cause;
    logic [31:0] host_irq_cause;
    logic [31:0] block_word;

    // Write strobes from both ports
    logic lb_wr_doorbell;
    logic lb_wr_cause;
    logic lb_wr_block;
    logic cfg_wr_doorbell;
    logic cfg_wr_cause;
    logic cfg_wr_block;

    // Set and clear terms
    logic [31:0] doorbell_set;
    logic [31:0] doorbell_clr;
    logic [1:0]  msg_set;
    logic [1:0]  msg_clr;

    // Local bus port
    access_port #(
        .DOORBELL_OFF (outbound_doorbell_pkg::LB_DOORBELL_OFF),
        .CAUSE_OFF    (outbound_doorbell_pkg::LB_CAUSE_OFF),
        .BLOCK_OFF    (outbound_doorbell_pkg::LB_BLOCK_OFF)
    ) u_lb_port (
        .clk           (clk),
        .srst          (srst),
        .req           (lb_req),
        .we            (lb_we),
        .addr          (lb_addr),
        .doorbell_word (host_doorbell_out),
        .cause_word    (host_irq_cause),
        .block_word    (block_word),
        .wr_doorbell   (lb_wr_doorbell),
        .wr_cause      (lb_wr_cause),
        .wr_block      (lb_wr_block),
        .ack           (lb_ack),
        .rdata         (lb_rdata)
    );

    // PCI configuration port
    access_port #(
        .DOORBELL_OFF (outbound_doorbell_pkg::CFG_DOORBELL_OFF),
        .CAUSE_OFF    (outbound_doorbell_pkg::CFG_CAUSE_OFF),
        .BLOCK_OFF    (outbound_doorbell_pkg::CFG_BLOCK_OFF)
    ) u_cfg_port (
        .clk           (clk),
        .srst          (srst),
        .req           (cfg_req),
        .we            (cfg_we),
        .addr          (cfg_addr),
        .doorbell_word (host_doorbell_out),
        .cause_word    (host_irq_cause),
        .block_word    (block_word),
        .wr_doorbell   (cfg_wr_doorbell),
        .wr_cause      (cfg_wr_cause),
        .wr_block      (cfg_wr_block),
        .ack           (cfg_ack),
        .rdata         (cfg_rdata)
    );

    // Local processor rings bits by writing ones; host clears by writing ones
    assign doorbell_set = lb_wr_doorbell ? lb_wdata : 32'h0000_0000;
    assign doorbell_clr = cfg_wr_doorbell ? cfg_wdata : 32'h0000_0000; // [RULE5]

    // Doorbell next value, a new ring beats a simultaneous clear
    always_comb begin
        next_doorbell = (host_doorbell_out & ~doorbell_clr) | doorbell_set;
    end

    always_ff @(posedge clk) begin
        if (srst) host_doorbell_out <= outbound_doorbell_pkg::DOORBELL_RESET;
        else      host_doorbell_out <= next_doorbell;
    end

    // Message flags: set by message writes, cleared by writing ones
    assign msg_set = {msg1_written, msg0_written}; // [RULE9]
    assign msg_clr = (lb_wr_cause ? lb_wdata[1:0] : 2'h0)   // [RULE10]
                   | (cfg_wr_cause ? cfg_wdata[1:0] : 2'h0); // [RULE12]

    // Set wins over clear in the same cycle
    always_comb begin
        next_msg_flag = (msg_flag & ~msg_clr) | msg_set; // [RULE9]
    end

    always_ff @(posedge clk) begin
        if (srst) msg_flag <= outbound_doorbell_pkg::MSG_RESET;
        else      msg_flag <= next_msg_flag;
    end

    // Block register, writable from both sides; host write wins a tie
    always_comb begin
        next_block = host_irq_block;
        if (lb_wr_block)
            next_block = {1'b0, lb_wdata[outbound_doorbell_pkg::BLOCK_MSB:0]};
        if (cfg_wr_block)
            next_block = {1'b0, cfg_wdata[outbound_doorbell_pkg::BLOCK_MSB:0]}; // [RULE18]
    end

    always_ff @(posedge clk) begin
        if (srst) host_irq_block <= outbound_doorbell_pkg::BLOCK_RESET; // [RULE13]
        else      host_irq_block <= next_block;
    end

    // Cause bits follow their sources; only the message bits hold state
    assign cause[outbound_doorbell_pkg::ST_LINE_D_BIT:outbound_doorbell_pkg::ST_LINE_A_BIT] =
        host_doorbell_out[outbound_doorbell_pkg::DB_LINE_D_BIT:
                          outbound_doorbell_pkg::DB_LINE_A_BIT]; // [RULE6] [RULE1] [RULE2]
    assign cause[outbound_doorbell_pkg::ST_POSTQ_BIT] = postq_head != postq_tail; // [RULE7]
    assign cause[outbound_doorbell_pkg::ST_SOFT_BIT]  =
        |host_doorbell_out[outbound_doorbell_pkg::DB_SOFT_MSB:0]; // [RULE3] [RULE8]
    assign cause[outbound_doorbell_pkg::ST_MSG1_BIT:outbound_doorbell_pkg::ST_MSG0_BIT] =
        msg_flag;

    // Read words, reserved upper bits as zero
    assign host_irq_cause = {24'h00_0000, cause}; // [RULE11]
    assign block_word     = {24'h00_0000, host_irq_block};

    // Line drivers
    irq_router u_router (
        .clk     (clk),
        .srst    (srst),
        .cause   (cause),
        .block   (host_irq_block),
        .pin_sel (irq_pin_sel),
        .line_oe (host_irq_line_n_oe)
    );

    // Open drain: only ever pulls low
    assign host_irq_line_n_out = 4'h0;
endmodule
`default_nettype wire

// File: outbound_doorbell_pkg.sv
// Constants for the outbound doorbell interrupt unit.
// Assumes both access ports carry 32-bit words at byte offsets.
package outbound_doorbell_pkg;

    // Local bus register offsets
    localparam logic [15:0] LB_DOORBELL_OFF = 16'h132C;
    localparam logic [15:0] LB_CAUSE_OFF    = 16'h1330;
    localparam logic [15:0] LB_BLOCK_OFF    = 16'h1334;

    // PCI configuration register offsets
    localparam logic [15:0] CFG_DOORBELL_OFF = 16'h002C;
    localparam logic [15:0] CFG_CAUSE_OFF    = 16'h0030;
    localparam logic [15:0] CFG_BLOCK_OFF    = 16'h0034;

    // Doorbell field positions
    localparam int DB_LINE_D_BIT = 31;
    localparam int DB_LINE_C_BIT = 30;
    localparam int DB_LINE_B_BIT = 29;
    localparam int DB_LINE_A_BIT = 28;
    localparam int DB_SOFT_MSB   = 27;

    // Cause and block field positions
    localparam int ST_LINE_D_BIT = 7;
    localparam int ST_LINE_A_BIT = 4;
    localparam int ST_POSTQ_BIT  = 3;
    localparam int ST_SOFT_BIT   = 2;
    localparam int ST_MSG1_BIT   = 1;
    localparam int ST_MSG0_BIT   = 0;
    localparam int BLOCK_MSB     = 6;

    // Reset values
    localparam logic [31:0] DOORBELL_RESET = 32'h0000_0000;
    localparam logic [7:0]  BLOCK_RESET    = 8'h00;
    localparam logic [1:0]  MSG_RESET      = 2'h0;

    // Interrupt pin selection codes (0 means no pin)
    localparam logic [2:0] PIN_NONE = 3'h0;
    localparam logic [2:0] PIN_A    = 3'h1;
    localparam logic [2:0] PIN_D    = 3'h4;
endpackage

// File: pci_host_model.sv
// Host model issuing configuration reads and writes.
// Assumes the unit answers on the taking edge.
`timescale 1ns/1ps
`default_nettype none
module pci_host_model (
    input  wire logic        clk,
    output logic             cfg_req,
    output logic             cfg_we,
    output logic [15:0]      cfg_addr,
    output logic [31:0]      cfg_wdata,
    input  wire logic        cfg_ack,
    input  wire logic [31:0] cfg_rdata
);
    // Idle bus at time zero
    initial begin
        cfg_req = 1'b0;
        cfg_we = 1'b0;
        cfg_addr = 16'h0000;
        cfg_wdata = 32'h0;
    end
    // One access after g idle cycles; released lines show inverted data
    task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d,
                          input int g, output logic [31:0] q);
        repeat (g) @(posedge clk);
        @(posedge clk) #1;
        cfg_req = 1'b1;
        cfg_we = w;
        cfg_addr = a;
        cfg_wdata = d;
        @(posedge clk) #1;
        cfg_req = 1'b0;
        cfg_addr = ~a;
        cfg_wdata = ~d;
        q = cfg_ack ? cfg_rdata : 32'hDEAD_BEEF;
    endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the outbound doorbell interrupt unit.
// Assumes the host model drives the configuration port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        lb_req = 1'b0;
    logic        lb_we = 1'b0;
    logic [15:0] lb_addr = 16'h0000;
    logic [31:0] lb_wdata = 32'h0;
    logic        msg0 = 1'b0;
    logic        msg1 = 1'b0;
    logic [15:0] head = 16'h0000;
    logic [15:0] tail = 16'h0000;
    logic [2:0]  pin = 3'h0;
    logic        lb_ack, cfg_req, cfg_we, cfg_ack;
    logic [15:0] cfg_addr;
    logic [31:0] lb_rdata, cfg_wdata, cfg_rdata, rd;
    logic [3:0]  oe;
    int          failures = 0;
    int          total_checks = 0;
    outbound_doorbell_interrupt_unit i_outbound_doorbell_interrupt_unit (
        .clk(clk), .srst(srst), .lb_req(lb_req), .lb_we(lb_we), .lb_addr(lb_addr),
        .lb_wdata(lb_wdata), .lb_ack(lb_ack), .lb_rdata(lb_rdata), .cfg_req(cfg_req),
        .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .msg0_written(msg0), .msg1_written(msg1),
        .postq_head(head), .postq_tail(tail), .irq_pin_sel(pin),
        .host_irq_line_n_out(), .host_irq_line_n_oe(oe));
    pci_host_model i_pci_host_model (.clk(clk), .cfg_req(cfg_req), .cfg_we(cfg_we),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
    // Clock
    always #20 clk = ~clk;
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    // Local access, answer read one cycle later
    task automatic lb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk) #1;
        lb_req = 1'b1;
        lb_we = w;
        lb_addr = a;
        lb_wdata = d;
        @(posedge clk) #1;
        lb_req = 1'b0;
        lb_wdata = ~d;
        rd = lb_ack ? lb_rdata : 32'hDEAD_BEEF;
    endtask
    // Configuration access through the host model
    task automatic cf(input logic w, input logic [15:0] a, input logic [31:0] d);
        i_pci_host_model.access(w, a, d, 1, rd);
    endtask
    // Let lines follow their cause
    task automatic oe_is(input logic [3:0] e);
        repeat (2) @(posedge clk);
        #1 check({28'h0, oe}, {28'h0, e});
    endtask
    // Reset values and doorbell lines A and B
    task automatic t_lines;
        for (int i = 0; i < 3; i++) begin
            lb(1'b0, 16'h132C + 16'(4 * i), 32'h0);
            check(rd, 32'h0);
        end
        lb(1'b1, 16'h132C, 32'h3000_0000);
        oe_is(4'h3);
        lb(1'b0, 16'h1330, 32'h0);
        check(rd, 32'h30);
        cf(1'b1, 16'h002C, 32'h1000_0000);
        oe_is(4'h2);
        cf(1'b1, 16'h002C, 32'h2000_0000);
        oe_is(4'h0);
        $display("lines done");
    endtask
    // Soft bits on every selectable pin
    task automatic t_soft;
        for (int p = 1; p < 5; p++) begin
            pin = 3'(p);
            lb(1'b1, 16'h132C, 32'h1 << (9 * p - 9));
            oe_is(4'(1 << (p - 1)));
            lb(1'b0, 16'h1330, 32'h0);
            check(rd, 32'h4);
            cf(1'b1, 16'h002C, 32'h1 << (9 * p - 9));
            oe_is(4'h0);
        end
        $display("soft done");
    endtask
    // Mask of soft bits and line A
    task automatic t_block;
        pin = 3'h1;
        lb(1'b1, 16'h132C, 32'h20);
        cf(1'b1, 16'h0034, 32'h4);
        oe_is(4'h0);
        cf(1'b1, 16'h0034, 32'hFFFF_FFFF);
        cf(1'b0, 16'h0034, 32'h0);
        check(rd, 32'h7F);
        lb(1'b1, 16'h132C, 32'h1000_0000);
        oe_is(4'h0);
        lb(1'b0, 16'h1330, 32'h0);
        check(rd, 32'h14);
        cf(1'b1, 16'h0034, 32'h0);
        oe_is(4'h1);
        cf(1'b1, 16'h002C, 32'h1000_0020);
        oe_is(4'h0);
        $display("block done");
    endtask
    // Message flags: set, mask, clear
    task automatic t_msg;
        pin = 3'h2;
        for (int m = 0; m < 2; m++) begin
            @(posedge clk) #1;
            msg0 = (m == 0);
            msg1 = (m == 1);
            @(posedge clk) #1;
            msg0 = 1'b0;
            msg1 = 1'b0;
            oe_is(4'h2);
            lb(1'b0, 16'h1330, 32'h0);
            check(rd, 32'h1 << m);
            cf(1'b1, 16'h0034, 32'h1 << m);
            oe_is(4'h0);
            lb(1'b1, 16'h1330, 32'h1 << m);
            lb(1'b0, 16'h1330, 32'h0);
            check(rd, 32'h0);
            cf(1'b1, 16'h0034, 32'h0);
        end
        $display("msg done");
    endtask
    // Post queue pointers
    task automatic t_postq;
        pin = 3'h3;
        @(posedge clk) #1;
        head = 16'h0005;
        oe_is(4'h4);
        lb(1'b0, 16'h1330, 32'h0);
        check(rd, 32'h8);
        cf(1'b1, 16'h0034, 32'h8);
        oe_is(4'h0);
        cf(1'b1, 16'h0034, 32'h0);
        tail = 16'h0005;
        oe_is(4'h0);
        $display("postq done");
    endtask
    // No pin selected, host clears a message flag, local mask write, reset
    task automatic t_misc;
        pin = 3'h0;
        lb(1'b1, 16'h132C, 32'h0000_0100);
        oe_is(4'h0);
        pin = 3'h5;
        oe_is(4'h0);
        lb(1'b0, 16'h1330, 32'h0);
        check(rd, 32'h4);
        cf(1'b1, 16'h002C, 32'h0000_0100);
        @(posedge clk) #1;
        msg1 = 1'b1;
        @(posedge clk) #1;
        msg1 = 1'b0;
        cf(1'b1, 16'h0030, 32'hFFFF_FFFF);
        lb(1'b0, 16'h1330, 32'h0);
        check(rd, 32'h0);
        lb(1'b1, 16'h1334, 32'h0000_0004);
        lb(1'b0, 16'h1334, 32'h0);
        check(rd, 32'h4);
        lb(1'b1, 16'h1334, 32'h0);
        lb(1'b1, 16'h132C, 32'h1000_0000);
        @(posedge clk) #1;
        check({28'h0, oe}, 32'h1);
        srst = 1'b1;
        @(posedge clk) #1;
        srst = 1'b0;
        check({28'h0, oe}, 32'h0);
        lb(1'b0, 16'h132C, 32'h0);
        check(rd, 32'h0);
        $display("misc done");
    endtask
    // Verdict
    task automatic wrap_up;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        #1 srst = 1'b0;
        t_lines;
        t_soft;
        t_block;
        t_msg;
        t_postq;
        t_misc;
        wrap_up;
    end
    // Watchdog
    initial begin
        #100000;
        failures++;
        wrap_up;
    end
endmodule
`default_nettype wire
